// File: hw/spiq_pkg.sv
// spiq_pkg: register map, field positions, carriers and timing for the
// spi master queue and select block.
// assumes a 40 MHz core clock and a 16-bit configuration-port address.
package spiq_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] OFF_EVENT = 16'h2024;
  localparam logic [15:0] OFF_MASK = 16'h2028;
  localparam logic [15:0] OFF_CMD = 16'h202c;
  localparam logic [15:0] OFF_TX = 16'h2030;
  localparam logic [15:0] OFF_RX = 16'h2034;
  localparam logic [15:0] OFF_SEL = 16'h2038;
  localparam logic [15:0] OFF_ASEL = 16'h203c;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CMD_LT_BIT = 22;
  localparam int EV_TIP_BIT = 31;
  localparam int EV_LT_BIT = 14;
  localparam int EV_OV_BIT = 12;
  localparam int EV_NE_BIT = 9;
  localparam int EV_NF_BIT = 8;
  localparam logic [31:0] MASK_WR_BITS = 32'h8000_5f00;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam int NSEL = 6;
  localparam logic [5:0] SEL_RESET = 6'h3f;
  localparam logic [5:0] ASEL_RESET = 6'h3f;
  localparam logic [3:0] WS_32BIT = 4'h0;
  localparam int RX_HALF_SHIFT = 16;

  // ---------------------------------------------------------------
  // timing: fastest serial clock, core clock divided by four
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCK_HALF_NS = 50;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } spiq_cfg_req_t;

  typedef struct packed {
    logic [3:0] word_size;
    logic msb_first_order;
    logic auto_sel_swap;
  } spiq_mode_t;

  typedef enum logic [1:0] {
    SPIQ_IDLE,
    SPIQ_SHIFT
  } spiq_state_t;

endpackage

// File: hw/spiq_top.sv
// spiq_top: command, transmit, receive and select registers of an spi
// master, with its transmit and receive queues and the serial engine.
// assumes mode settings arrive as levels from the mode register elsewhere
// and the configuration port gives one-cycle read and write strobes.
`timescale 1ns/1ps

module spiq_top #(
  parameter int TXQ_DEPTH = 4,
  parameter int RXQ_DEPTH = 4,
  parameter int HALF_CYC = spiq_pkg::SCK_HALF_CYC
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // configuration port
  input wire spiq_pkg::spiq_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // mode settings
  input wire spiq_pkg::spiq_mode_t mode,
  // serial pins and transfer status
  output logic sck,
  output logic mosi,
  input wire logic miso,
  output logic [spiq_pkg::NSEL-1:0] chip_select_lines,
  output logic transfer_active
);
  import spiq_pkg::*;

  localparam int TPW = $clog2(TXQ_DEPTH);
  localparam int RPW = $clog2(RXQ_DEPTH);
  localparam logic [TPW:0] TX_FULL = (TPW+1)'(TXQ_DEPTH);
  localparam logic [RPW:0] RX_FULL = (RPW+1)'(RXQ_DEPTH);
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic miso_meta, miso_sync;
  logic [31:0] txq [TXQ_DEPTH];
  logic [31:0] rxq [RXQ_DEPTH];
  logic [TPW-1:0] tx_wp, tx_rp;
  logic [RPW-1:0] rx_wp, rx_rp;
  logic [TPW:0] tx_cnt;
  logic [RPW:0] rx_cnt;
  logic [31:0] event_enables;
  logic [5:0] sel_primary, alt_chip_select_lines;
  logic eoq_marker, final_word_event, rx_lost_word, alt_active;
  spiq_state_t state;
  logic [31:0] tx_shift, rx_shift;
  logic [7:0] div_cnt;
  logic [5:0] bit_cnt;

  logic [31:0] next_txq [TXQ_DEPTH];
  logic [31:0] next_rxq [RXQ_DEPTH];
  logic [TPW-1:0] next_tx_wp, next_tx_rp;
  logic [RPW-1:0] next_rx_wp, next_rx_rp;
  logic [TPW:0] next_tx_cnt;
  logic [RPW:0] next_rx_cnt;
  logic [31:0] next_event_enables, next_cfg_rdata;
  logic [5:0] next_sel_primary, next_alt_chip_select_lines;
  logic next_eoq_marker, next_final_word_event, next_rx_lost_word;
  logic next_alt_active, next_sck, next_cfg_rvalid;
  spiq_state_t next_state;
  logic [31:0] next_tx_shift, next_rx_shift;
  logic [7:0] next_div_cnt;
  logic [5:0] next_bit_cnt;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  logic tx_space_avail, rx_has_words, cmd_lt_write, tx_push, word_done;
  logic [5:0] word_len;
  logic [31:0] rx_placed, rx_shifted, event_view;

  assign tx_space_avail = (tx_cnt != TX_FULL);
  assign rx_has_words = (rx_cnt != '0);
  assign word_len = (mode.word_size == WS_32BIT) ? 6'h20 :
                    {2'b00, mode.word_size} + 6'h01;
  assign cmd_lt_write = cfg_req.wr && cfg_req.addr == OFF_CMD &&
                        cfg_req.wdata[CMD_LT_BIT];
  assign tx_push = cfg_req.wr && cfg_req.addr == OFF_TX &&
                   tx_space_avail;
  assign word_done = state == SPIQ_SHIFT && div_cnt == HALF_LAST && sck &&
                     bit_cnt == word_len - 6'h01;
  // incoming bit lands at the end the shift direction fills from
  always_comb begin
    rx_shifted = mode.msb_first_order ? {rx_shift[30:0], miso_sync} :
                 {miso_sync, rx_shift[31:1]};
    // placement acts on the finished word only, never inside the shifter
    rx_placed = rx_shift;
    if (mode.word_size != WS_32BIT) begin
      rx_placed = mode.msb_first_order ? rx_shift << RX_HALF_SHIFT :
                  rx_shift >> RX_HALF_SHIFT;
    end
  end
  always_comb begin
    event_view = '0;
    event_view[EV_TIP_BIT] = transfer_active;
    event_view[EV_LT_BIT] = final_word_event;
    event_view[EV_OV_BIT] = rx_lost_word;
    event_view[EV_NE_BIT] = rx_has_words;
    event_view[EV_NF_BIT] = tx_space_avail;
  end

  assign transfer_active = (state == SPIQ_SHIFT);
  assign mosi = mode.msb_first_order ? tx_shift[31] : tx_shift[0];
  assign chip_select_lines = alt_active ? alt_chip_select_lines :
                             sel_primary;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_txq = txq;
    next_rxq = rxq;
    next_tx_wp = tx_wp;
    next_tx_rp = tx_rp;
    next_rx_wp = rx_wp;
    next_rx_rp = rx_rp;
    next_tx_cnt = tx_cnt;
    next_rx_cnt = rx_cnt;
    next_event_enables = event_enables;
    next_sel_primary = sel_primary;
    next_alt_chip_select_lines = alt_chip_select_lines;
    next_eoq_marker = eoq_marker;
    next_final_word_event = final_word_event;
    next_rx_lost_word = rx_lost_word;
    next_alt_active = alt_active;
    next_state = state;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_div_cnt = div_cnt;
    next_bit_cnt = bit_cnt;
    next_sck = sck;
    next_cfg_rvalid = cfg_req.rd;
    next_cfg_rdata = '0;

    // register reads; command and unmapped offsets answer zero
    if (cfg_req.rd) begin
      case (cfg_req.addr)
        OFF_EVENT: next_cfg_rdata = event_view;
        OFF_MASK: next_cfg_rdata = event_enables;
        OFF_CMD: next_cfg_rdata = '0;
        OFF_TX: next_cfg_rdata = txq[tx_wp - TPW'(1)];
        OFF_RX: next_cfg_rdata = rx_has_words ? rxq[rx_rp] : '0;
        OFF_SEL: next_cfg_rdata = {26'h0, sel_primary};
        OFF_ASEL: next_cfg_rdata = {26'h0, alt_chip_select_lines};
        default: next_cfg_rdata = '0;
      endcase
      if (cfg_req.addr == OFF_RX && rx_has_words) begin
        next_rx_rp = rx_rp + RPW'(1);
        next_rx_cnt = next_rx_cnt - (RPW+1)'(1);
      end
    end

    // register writes; clears first so a same-cycle event wins
    if (cfg_req.wr) begin
      case (cfg_req.addr)
        OFF_MASK: next_event_enables = cfg_req.wdata & MASK_WR_BITS;
        OFF_EVENT: begin
          if (cfg_req.wdata[EV_LT_BIT]) next_final_word_event = 1'b0;
          if (cfg_req.wdata[EV_OV_BIT]) next_rx_lost_word = 1'b0;
        end
        OFF_SEL: next_sel_primary = cfg_req.wdata[5:0];
        OFF_ASEL: next_alt_chip_select_lines = cfg_req.wdata[5:0];
        default: ;
      endcase
    end
    if (tx_push) begin
      next_txq[tx_wp] = cfg_req.wdata;
      next_tx_wp = tx_wp + TPW'(1);
      next_tx_cnt = next_tx_cnt + (TPW+1)'(1);
    end

    // serial engine
    case (state)
      SPIQ_IDLE: begin
        next_sck = 1'b0;
        next_div_cnt = '0;
        next_bit_cnt = '0;
        if (tx_cnt != '0) begin
          next_tx_shift = txq[tx_rp];
          next_rx_shift = '0;
          next_tx_rp = tx_rp + TPW'(1);
          next_tx_cnt = next_tx_cnt - (TPW+1)'(1);
          next_alt_active = mode.auto_sel_swap;
          next_state = SPIQ_SHIFT;
        end
      end
      SPIQ_SHIFT: begin
        next_div_cnt = div_cnt + 8'h01;
        if (div_cnt == HALF_LAST) begin
          next_div_cnt = '0;
          next_sck = ~sck;
          if (!sck) begin
            next_rx_shift = rx_shifted;
          end else if (word_done) begin
            next_bit_cnt = '0;
            if (rx_cnt != RX_FULL) begin
              next_rxq[rx_wp] = rx_placed;
              next_rx_wp = rx_wp + RPW'(1);
              next_rx_cnt = next_rx_cnt + (RPW+1)'(1);
            end else begin
              next_rx_lost_word = 1'b1;
            end
            if (tx_cnt != '0) begin
              // back-to-back word, select stays where it is
              next_tx_shift = txq[tx_rp];
              next_rx_shift = '0;
              next_tx_rp = tx_rp + TPW'(1);
              next_tx_cnt = next_tx_cnt - (TPW+1)'(1);
            end else begin
              next_state = SPIQ_IDLE;
              next_alt_active = 1'b0;
              if (eoq_marker) begin
                next_final_word_event = 1'b1;
                next_eoq_marker = 1'b0;
              end
            end
          end else begin
            next_bit_cnt = bit_cnt + 6'h01;
            next_tx_shift = mode.msb_first_order ? tx_shift << 1 :
                            tx_shift >> 1;
          end
        end
      end
      default: next_state = SPIQ_IDLE;
    endcase

    // a fresh marker write outlives an auto-clear in the same cycle
    if (cmd_lt_write) next_eoq_marker = 1'b1;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      miso_meta <= 1'b0;
      miso_sync <= 1'b0;
      for (int i = 0; i < TXQ_DEPTH; i++) txq[i] <= '0;
      for (int i = 0; i < RXQ_DEPTH; i++) rxq[i] <= '0;
      tx_wp <= '0;
      tx_rp <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
      tx_cnt <= '0;
      rx_cnt <= '0;
      event_enables <= MASK_RESET;
      sel_primary <= SEL_RESET;
      alt_chip_select_lines <= ASEL_RESET;
      eoq_marker <= 1'b0;
      final_word_event <= 1'b0;
      rx_lost_word <= 1'b0;
      alt_active <= 1'b0;
      state <= SPIQ_IDLE;
      tx_shift <= '0;
      rx_shift <= '0;
      div_cnt <= '0;
      bit_cnt <= '0;
      sck <= 1'b0;
      cfg_rvalid <= 1'b0;
      cfg_rdata <= '0;
    end else if (clk_en) begin
      miso_meta <= miso;
      miso_sync <= miso_meta;
      txq <= next_txq;
      rxq <= next_rxq;
      tx_wp <= next_tx_wp;
      tx_rp <= next_tx_rp;
      rx_wp <= next_rx_wp;
      rx_rp <= next_rx_rp;
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
      event_enables <= next_event_enables;
      sel_primary <= next_sel_primary;
      alt_chip_select_lines <= next_alt_chip_select_lines;
      eoq_marker <= next_eoq_marker;
      final_word_event <= next_final_word_event;
      rx_lost_word <= next_rx_lost_word;
      alt_active <= next_alt_active;
      state <= next_state;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      div_cnt <= next_div_cnt;
      bit_cnt <= next_bit_cnt;
      sck <= next_sck;
      cfg_rvalid <= next_cfg_rvalid;
      cfg_rdata <= next_cfg_rdata;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_cmd_reads_zero;
    clk_en && cfg_req.rd && cfg_req.addr == OFF_CMD |=> cfg_rdata == '0;
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero)
    else $error("command register read not zero");

  property p_tx_push;
    clk_en && tx_push |=> tx_wp == $past(tx_wp) + TPW'(1);
  endproperty
  a_tx_push: assert property (p_tx_push)
    else $error("tx write not queued");

  property p_tx_drop_full;
    clk_en && cfg_req.wr && cfg_req.addr == OFF_TX && !tx_space_avail
      |=> tx_wp == $past(tx_wp);
  endproperty
  a_tx_drop_full: assert property (p_tx_drop_full)
    else $error("tx write accepted while full");

  property p_space_flag;
    tx_space_avail == (tx_cnt < TX_FULL) && event_view[EV_NF_BIT] ==
      tx_space_avail;
  endproperty
  a_space_flag: assert property (p_space_flag)
    else $error("tx space flag wrong");

  property p_rx_flag;
    event_view[EV_NE_BIT] == (rx_cnt > '0);
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("rx has words flag wrong");

  property p_lt_needs_marker;
    $rose(final_word_event) |-> $past(eoq_marker) && $past(tx_cnt) == '0;
  endproperty
  a_lt_needs_marker: assert property (p_lt_needs_marker)
    else $error("final word event without marker");

  property p_lt_clears_marker;
    $rose(final_word_event) && !$past(cmd_lt_write) |-> !eoq_marker;
  endproperty
  a_lt_clears_marker: assert property (p_lt_clears_marker)
    else $error("marker not cleared with event");

  property p_overrun;
    clk_en && word_done && rx_cnt == RX_FULL &&
      !(cfg_req.rd && cfg_req.addr == OFF_RX)
      |=> rx_lost_word && rx_cnt == RX_FULL;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_alt_select;
    alt_active |-> chip_select_lines == alt_chip_select_lines &&
      transfer_active;
  endproperty
  a_alt_select: assert property (p_alt_select)
    else $error("alternate select not driven");

  property p_idle_primary;
    state == SPIQ_IDLE && !alt_active |-> chip_select_lines == sel_primary;
  endproperty
  a_idle_primary: assert property (p_idle_primary)
    else $error("idle select not primary");

  property p_short_word_place;
    word_done && mode.word_size != WS_32BIT && !mode.msb_first_order
      |-> rx_placed[31:16] == '0;
  endproperty
  a_short_word_place: assert property (p_short_word_place)
    else $error("short word misplaced");

  c_final_word: cover property ($rose(final_word_event));
  c_overrun: cover property ($rose(rx_lost_word));
  c_alt_active: cover property ($rose(alt_active));
  c_tx_full: cover property (!tx_space_avail);

endmodule

// File: tb/spiq_slave.sv
// spiq_slave: behavioural spi slave for the queue and select bench.
// assumes clock idle low with data taken on the rising sck edge.
`timescale 1ns/1ps
module spiq_slave (
  // serial pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic [5:0] chip_select_lines,
  // reply pin, bench control and observation
  input wire logic fill,
  output logic miso,
  output int nbits,
  output logic [31:0] got
);
  // ---------------------------------------------------------------
  // receive side and reply
  // ---------------------------------------------------------------
  initial begin
    nbits = 0;
    got = 32'h0;
  end
  // deselected: drive the inverse so stale data cannot pass for valid
  assign miso = (&chip_select_lines) ? ~fill : fill;
  always @(posedge sck) begin
    got <= {got[30:0], mosi};
    nbits <= nbits + 1;
  end
endmodule

// File: tb/spiq_top_test.sv
// spiq_top_test: self-checking bench for the spi queue and select block.
// assumes spiq_slave on the serial side and a short sck half period.
`timescale 1ns/1ps
module spiq_top_test;
  import spiq_pkg::*;
  logic core_clk = 0, rst_b = 0, clk_en = 1, fill = 0;
  spiq_cfg_req_t cfg_req = '0;
  spiq_mode_t mode = '0;
  logic [31:0] cfg_rdata, got, r;
  logic cfg_rvalid, sck, mosi, miso, transfer_active;
  logic [5:0] chip_select_lines;
  int nbits, n_mismatch = 0, checked = 0, seed, i, n0;
  logic [3:0] sizes [4] = '{4'h0, 4'h3, 4'h7, 4'hf};

  spiq_top #(.HALF_CYC(1)) spiq_top_inst (.core_clk(core_clk),
    .rst_b(rst_b), .clk_en(clk_en), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .mode(mode),
    .sck(sck), .mosi(mosi), .miso(miso),
    .chip_select_lines(chip_select_lines),
    .transfer_active(transfer_active));
  spiq_slave spiq_slave_inst (.sck(sck), .mosi(mosi),
    .chip_select_lines(chip_select_lines), .fill(fill), .miso(miso),
    .nbits(nbits), .got(got));

  initial forever #12.5 core_clk = ~core_clk;
  initial begin
    #2_000_000;
    n_mismatch++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // compare, bus and wait tasks
  // ---------------------------------------------------------------
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_sel(input logic [5:0] g, input logic [5:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t select %h expected %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge core_clk);
    cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    cfg_req = '0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    int k;
    @(negedge core_clk);
    cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(negedge core_clk);
    cfg_req = '0;
    for (k = 0; k < 4 && cfg_rvalid !== 1'b1; k++) @(negedge core_clk);
    if (cfg_rvalid !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
    chk_word(cfg_rdata, e);
  endtask
  task automatic wait_act;
    int k;
    for (k = 0; k < 400 && transfer_active !== 1'b1; k++)
      @(negedge core_clk);
    if (transfer_active !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic wait_idle;
    int k;
    for (k = 0; k < 4000 && transfer_active !== 1'b0; k++)
      @(negedge core_clk);
    if (transfer_active !== 1'b0) begin
      n_mismatch++;
      report_and_stop();
    end
    repeat (4) @(negedge core_clk);
  endtask

  // expected receive placement for a word of constant fill level
  function automatic logic [31:0] rx_word(int n, logic rv, logic f);
    logic [31:0] m;
    m = (n == 32) ? 32'hffff_ffff : (32'h1 << n) - 32'h1;
    if (!f) return 32'h0;
    if (n == 32) return m;
    return rv ? m << 16 : m << (16 - n);
  endfunction

  task automatic xfer(input logic [3:0] ws, input logic rv,
                      input logic [31:0] ev);
    int n, k, b;
    logic [31:0] tx, ex, m;
    n = (ws == WS_32BIT) ? 32 : int'(ws) + 1;
    tx = $urandom();
    fill = 1'($urandom());
    mode.word_size = ws;
    mode.msb_first_order = rv;
    b = nbits;
    wr(OFF_TX, tx);
    wait_act();
    wait_idle();
    chk_word(32'(nbits - b), 32'(n));
    ex = 32'h0;
    for (k = 0; k < n; k++) ex = {ex[30:0], rv ? tx[31 - k] : tx[k]};
    m = (n == 32) ? 32'hffff_ffff : (32'h1 << n) - 32'h1;
    chk_word(got & m, ex);
    rd_chk(OFF_EVENT, ev);
    rd_chk(OFF_RX, rx_word(n, rv, fill));
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = $urandom(32'h1f9d1615);
    repeat (6) @(negedge core_clk);
    rst_b = 1;
    chk_sel(chip_select_lines, SEL_RESET);
    rd_chk(OFF_SEL, 32'h3f);
    rd_chk(OFF_ASEL, {26'h0, ASEL_RESET});
    rd_chk(OFF_MASK, MASK_RESET);
    rd_chk(OFF_EVENT, 32'h100);
    wr(OFF_CMD, 32'hffbf_ffff);
    rd_chk(OFF_CMD, 32'h0);
    wr(OFF_MASK, 32'hffff_ffff);
    rd_chk(OFF_MASK, MASK_WR_BITS);
    rd_chk(16'h2040, 32'h0);
    wr(OFF_SEL, 32'hffff_ffc5);
    rd_chk(OFF_SEL, 32'h05);
    chk_sel(chip_select_lines, 6'h05);
    wr(OFF_SEL, 32'h3e);
    // enable low freezes state: a write must not land
    clk_en = 1'b0;
    wr(OFF_SEL, 32'h15);
    chk_sel(chip_select_lines, 6'h3e);
    clk_en = 1'b1;
    // enables all set above must not change any transfer
    for (i = 0; i < 8; i++) xfer(sizes[i / 2], i[0], 32'h300);
    // automatic select swap over a two-word run
    wr(OFF_ASEL, 32'hffff_ff2a);
    mode.auto_sel_swap = 1'b1;
    mode.word_size = 4'h7;
    mode.msb_first_order = 1'b0;
    wr(OFF_TX, $urandom());
    wr(OFF_TX, $urandom());
    wait_act();
    chk_sel(chip_select_lines, 6'h2a);
    wait_idle();
    chk_sel(chip_select_lines, 6'h3e);
    rd_chk(OFF_RX, rx_word(8, 1'b0, fill));
    rd_chk(OFF_RX, rx_word(8, 1'b0, fill));
    mode.auto_sel_swap = 1'b0;
    // end-of-queue marker, then a word without it
    wr(OFF_CMD, 32'h0040_0000);
    xfer(4'h7, 1'b0, 32'h4300);
    wr(OFF_EVENT, 32'h0000_4000);
    xfer(4'h7, 1'b0, 32'h300);
    // overfill the transmit queue, then overrun the receive queue
    n0 = nbits;
    for (i = 0; i < 5; i++) wr(OFF_TX, $urandom());
    rd_chk(OFF_EVENT, 32'h8000_0000);
    wr(OFF_TX, $urandom());
    wait_idle();
    chk_word(32'(nbits - n0), 32'd40);
    rd_chk(OFF_EVENT, 32'h1300);
    for (i = 0; i < 4; i++) rd_chk(OFF_RX, rx_word(8, 1'b0, fill));
    rd_chk(OFF_EVENT, 32'h1100);
    rd_chk(OFF_RX, 32'h0);
    report_and_stop();
  end
endmodule
